// ### pkg/rxirq_consts.svh
// timing counts and bit positions for the reset and interrupt pin block
`ifndef RXIRQ_CONSTS_SVH
`define RXIRQ_CONSTS_SVH
`define RXIRQ_CLK_PERIOD_NS 10
`define RXIRQ_RELEASE_CYCLES 16
`define RXIRQ_RELEASE_CNT_W 8
`define RXIRQ_POR_CYCLES 8
`define RXIRQ_SYNC_STAGES 2
`define RXIRQ_PUD_RESET_BIT 0
`define RXIRQ_PUD_IRQ_BIT 1
`define RXIRQ_PUD_XBOOT_BIT 2
`define RXIRQ_PUD_W 3
`define RXIRQ_PUD_RESET_VAL 3'h0
`endif

// ### pkg/rxirq_pkg.sv
// types for the reset and interrupt pin block
package rxirq_pkg;
   typedef enum logic [1:0] {
      RXIRQ_ST_POR,
      RXIRQ_ST_HELD,
      RXIRQ_ST_COUNT,
      RXIRQ_ST_RUN
   } rxirq_rst_state_t;
   typedef enum logic {
      RXIRQ_SENSE_LEVEL,
      RXIRQ_SENSE_EDGE
   } rxirq_sense_t;
endpackage : rxirq_pkg

// ### pkg/rxirq_req_if.sv
// one conditioned external request between top and channel
`timescale 1ns/100ps
interface rxirq_req_if;
   logic pin_n;
   logic low_power;
   logic edge_mode;
   logic ack;
   logic pending;
   modport chan (input pin_n, input low_power, input edge_mode, input ack, output pending);
   modport top (output pin_n, output low_power, output edge_mode, output ack, input pending);
endinterface : rxirq_req_if

// ### design/rxirq_sync.sv
// two-stage synchroniser for one level
`timescale 1ns/100ps
module rxirq_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic d_in,
   output logic q_out
);
   logic [STAGES-1:0] chain_ff;

   // one stage would hand a possibly metastable level straight on
   if (STAGES < 2) begin : g_bad_stages
      $error("rxirq_sync needs at least two stages");
   end

   // reset value is the idle-high pin level
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         chain_ff <= '1;
      end else begin
         chain_ff <= {chain_ff[STAGES-2:0], d_in}; // RL15
      end
   end

   assign q_out = chain_ff[STAGES-1];
endmodule : rxirq_sync

// ### design/rxirq_chan.sv
// one external request channel: sync or bypass, level or edge sensing
`timescale 1ns/100ps
`include "rxirq_consts.svh"
module rxirq_chan (
   input wire logic clk_in,
   input wire logic reset_in,
   rxirq_req_if.chan req
);
   logic synced;
   logic sel_level;
   logic prev_ff;
   logic edge_pend_ff;
   logic fall;

   rxirq_sync #(.STAGES(`RXIRQ_SYNC_STAGES)) u_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .d_in(req.pin_n),
      .q_out(synced)
   );

   // low power: raw pin, no sampling (clock may be gated)
   assign sel_level = req.low_power ? req.pin_n : synced; // RL9 RL10

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         prev_ff <= 1'b1;
      end else begin
         prev_ff <= sel_level;
      end
   end

   assign fall = prev_ff & ~sel_level;

   // set beats acknowledge in the same cycle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         edge_pend_ff <= 1'b0;
      end else if (req.edge_mode && fall) begin
         edge_pend_ff <= 1'b1; // RL14
      end else if (req.ack || !req.edge_mode) begin
         edge_pend_ff <= 1'b0;
      end
   end

   assign req.pending = req.edge_mode ? edge_pend_ff : ~sel_level; // RL11

   a_edge_held: assert property (@(posedge clk_in) disable iff (reset_in) // RL14
      req.edge_mode && fall |=> req.pending)
      else $error("falling edge not held pending");
   a_edge_ack: assert property (@(posedge clk_in) disable iff (reset_in) // RL14
      req.edge_mode && req.ack && !fall ##1 req.edge_mode |-> !req.pending)
      else $error("acknowledged edge still pending");
   // the chain is refilled with idle level by reset, so look back past it only
   a_level_follow: assert property (@(posedge clk_in) disable iff (reset_in) // RL10
      !req.edge_mode && !req.low_power && $past(!reset_in) && $past(!reset_in, 2)
      && $past(req.pin_n, 2) == 1'b0 |-> req.pending)
      else $error("synced level request missing");
   a_sync_lag: assert property (@(posedge clk_in) disable iff (reset_in) // RL15
      $past(!reset_in) && $past(!reset_in, 2) |-> synced == $past(req.pin_n, 2))
      else $error("synchroniser lag wrong");
endmodule : rxirq_chan

// ### design/rxirq_top.sv
// reset sequencing, boot mode capture and external request conditioning
//
// Behaviour
// RL1: reset pin low holds device in reset
// RL2: capture boot select pin at reset release
// RL3: internal reset released after fixed clock count
// RL4: controller asserts reset and test reset together
// RL5: device-only reset keeps debug state intact
// RL6: power-on reset asserts on first power-up
// RL7: reset pull-up disable bit kills reset pull-up
// RL8: reset state output follows internal reset
// RL9: stop and wait take requests asynchronously (here level-sensed only; edge requests still need the clocked edge_pend_ff)
// RL10: other modes synchronise requests first
// RL11: each request level or falling edge
// RL12: interrupt pull-up disable bit kills request pull-ups
// RL13: boot external if select high, not secured
// RL14: edge requests held pending until serviced
// RL15: two-stage synchroniser on request inputs
`timescale 1ns/100ps
`include "rxirq_consts.svh"
module rxirq_top #(
   parameter int RELEASE_CYCLES = `RXIRQ_RELEASE_CYCLES,
   parameter int POR_CYCLES = `RXIRQ_POR_CYCLES
) (
   // clock and synchronous reset (power-on)
   input wire logic clk_in,
   input wire logic reset_in,
   // board pins
   input wire logic device_reset_n_in,
   input wire logic test_reset_n_in,
   input wire logic boot_source_select_in,
   input wire logic external_request_a_n_in,
   input wire logic external_request_b_n_in,
   // system control
   input wire logic flash_secure_in,
   input wire logic low_power_mode_in,
   input wire logic [`RXIRQ_PUD_W-1:0] pullup_disable_reg_in,
   input wire logic sense_edge_a_in,
   input wire logic sense_edge_b_in,
   input wire logic ack_a_in,
   input wire logic ack_b_in,
   // results
   output logic core_reset_out,
   output logic debug_reset_out,
   output logic reset_state_out,
   output logic boot_mode_out,
   output logic boot_external_out,
   output logic request_a_out,
   output logic request_b_out,
   output logic reset_pullup_en_out,
   output logic irq_pullup_en_out,
   output logic boot_pullup_en_out
);
   rxirq_pkg::rxirq_rst_state_t state_ff;
   rxirq_pkg::rxirq_rst_state_t nxt_state;
   logic [`RXIRQ_RELEASE_CNT_W-1:0] cnt_ff;
   logic [`RXIRQ_RELEASE_CNT_W-1:0] nxt_cnt;
   logic core_reset_ff;
   logic debug_reset_ff;
   logic boot_mode_ff;
   logic boot_external_ff;
   logic req_a_ff;
   logic req_b_ff;

   localparam logic [`RXIRQ_RELEASE_CNT_W-1:0] REL_LAST = (`RXIRQ_RELEASE_CNT_W)'(RELEASE_CYCLES - 1);
   localparam logic [`RXIRQ_RELEASE_CNT_W-1:0] POR_LAST = (`RXIRQ_RELEASE_CNT_W)'(POR_CYCLES - 1);

   // the shared counter must reach the last value of either stretch
   if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > (1 << `RXIRQ_RELEASE_CNT_W)) begin : g_bad_release
      $error("RELEASE_CYCLES out of range");
   end
   if (POR_CYCLES < 1 || POR_CYCLES > (1 << `RXIRQ_RELEASE_CNT_W)) begin : g_bad_por
      $error("POR_CYCLES out of range");
   end

   // reset sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         rxirq_pkg::RXIRQ_ST_POR: begin
            // power-on stretch independent of the pin
            if (cnt_ff == POR_LAST) begin // RL6
               nxt_state = rxirq_pkg::RXIRQ_ST_HELD;
               nxt_cnt = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         rxirq_pkg::RXIRQ_ST_HELD: begin
            if (device_reset_n_in) begin
               nxt_state = rxirq_pkg::RXIRQ_ST_COUNT;
               nxt_cnt = '0;
            end
         end
         rxirq_pkg::RXIRQ_ST_COUNT: begin
            if (!device_reset_n_in) begin
               nxt_state = rxirq_pkg::RXIRQ_ST_HELD; // RL1
            end else if (cnt_ff == REL_LAST) begin
               nxt_state = rxirq_pkg::RXIRQ_ST_RUN; // RL3
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         rxirq_pkg::RXIRQ_ST_RUN: begin
            if (!device_reset_n_in) begin
               nxt_state = rxirq_pkg::RXIRQ_ST_HELD; // RL1
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_ff <= rxirq_pkg::RXIRQ_ST_POR;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // registered so the release lands on a clock edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         core_reset_ff <= 1'b1;
      end else begin
         core_reset_ff <= (nxt_state != rxirq_pkg::RXIRQ_ST_RUN); // RL1 RL3
      end
   end

   // debug logic follows only test reset and power-on, not the device pin
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         debug_reset_ff <= 1'b1;
      end else begin
         debug_reset_ff <= !test_reset_n_in; // RL5 RL4
      end
   end

   // boot pin latched on the release edge of the pin
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         boot_mode_ff <= 1'b0;
         boot_external_ff <= 1'b0;
      end else if (state_ff == rxirq_pkg::RXIRQ_ST_HELD && device_reset_n_in) begin
         boot_mode_ff <= boot_source_select_in; // RL2
         boot_external_ff <= boot_source_select_in && !flash_secure_in; // RL13
      end
   end

   assign core_reset_out = core_reset_ff;
   assign debug_reset_out = debug_reset_ff;
   assign reset_state_out = core_reset_ff; // RL8
   assign boot_mode_out = boot_mode_ff;
   assign boot_external_out = boot_external_ff;

   // pull-up enables are active while the disable bit is clear
   assign reset_pullup_en_out = !pullup_disable_reg_in[`RXIRQ_PUD_RESET_BIT]; // RL7
   assign irq_pullup_en_out = !pullup_disable_reg_in[`RXIRQ_PUD_IRQ_BIT]; // RL12
   assign boot_pullup_en_out = !pullup_disable_reg_in[`RXIRQ_PUD_XBOOT_BIT];

   // request channels; core reset also clears them
   rxirq_req_if req_a ();
   rxirq_req_if req_b ();

   assign req_a.pin_n = external_request_a_n_in;
   assign req_a.low_power = low_power_mode_in;
   assign req_a.edge_mode = (sense_edge_a_in == rxirq_pkg::RXIRQ_SENSE_EDGE);
   assign req_a.ack = ack_a_in;
   assign req_b.pin_n = external_request_b_n_in;
   assign req_b.low_power = low_power_mode_in;
   assign req_b.edge_mode = (sense_edge_b_in == rxirq_pkg::RXIRQ_SENSE_EDGE);
   assign req_b.ack = ack_b_in;

   rxirq_chan u_chan_a (
      .clk_in(clk_in),
      .reset_in(core_reset_ff),
      .req(req_a)
   );

   rxirq_chan u_chan_b (
      .clk_in(clk_in),
      .reset_in(core_reset_ff),
      .req(req_b)
   );

   // in low power a level-sensed request is combinational so a gated clock still wakes
   assign request_a_out = low_power_mode_in ? req_a.pending : req_a_ff; // RL9
   assign request_b_out = low_power_mode_in ? req_b.pending : req_b_ff; // RL9

   always_ff @(posedge clk_in) begin
      if (core_reset_ff) begin
         req_a_ff <= 1'b0;
         req_b_ff <= 1'b0;
      end else begin
         req_a_ff <= req_a.pending;
         req_b_ff <= req_b.pending;
      end
   end

   // assertion helper: edges the pin has stood high since power-on ended
   localparam logic [`RXIRQ_RELEASE_CNT_W:0] REL_EDGES = (`RXIRQ_RELEASE_CNT_W + 1)'(RELEASE_CYCLES);
   logic [`RXIRQ_RELEASE_CNT_W:0] pin_high_cnt_ff;

   // saturates so a long run never wraps back under the release count
   always_ff @(posedge clk_in) begin
      if (reset_in || !device_reset_n_in || state_ff == rxirq_pkg::RXIRQ_ST_POR) begin
         pin_high_cnt_ff <= '0;
      end else if (pin_high_cnt_ff != '1) begin
         pin_high_cnt_ff <= pin_high_cnt_ff + 1'b1;
      end
   end

   a_pin_holds: assert property (@(posedge clk_in) disable iff (reset_in) // RL1
      !device_reset_n_in |=> core_reset_out)
      else $error("core left reset while pin low");
   a_release_count: assert property (@(posedge clk_in) disable iff (reset_in) // RL3
      $rose(state_ff == rxirq_pkg::RXIRQ_ST_COUNT) && device_reset_n_in ##1 device_reset_n_in [*1]
      |-> core_reset_out)
      else $error("core reset released too early");
   // release lands on the edge after the counted ones, not earlier or later
   a_release_exact: assert property (@(posedge clk_in) disable iff (reset_in) // RL3
      state_ff != rxirq_pkg::RXIRQ_ST_POR |-> core_reset_out == (pin_high_cnt_ff > REL_EDGES ? 1'b0 : 1'b1))
      else $error("core reset release off count");
   a_req_masked: assert property (@(posedge clk_in) disable iff (reset_in) // RL1
      core_reset_out && $past(core_reset_out) && !low_power_mode_in |-> !request_a_out && !request_b_out)
      else $error("request seen during core reset");
   a_state_out: assert property (@(posedge clk_in) disable iff (reset_in) // RL8
      reset_state_out == core_reset_out)
      else $error("reset state output mismatch");
   a_boot_capture: assert property (@(posedge clk_in) disable iff (reset_in) // RL2
      state_ff == rxirq_pkg::RXIRQ_ST_HELD && device_reset_n_in
      |=> boot_mode_out == $past(boot_source_select_in))
      else $error("boot select not captured");
   a_boot_hold: assert property (@(posedge clk_in) disable iff (reset_in) // RL2
      !(state_ff == rxirq_pkg::RXIRQ_ST_HELD && device_reset_n_in)
      |=> $stable(boot_mode_out) && $stable(boot_external_out))
      else $error("boot mode changed outside release");
   a_boot_ext: assert property (@(posedge clk_in) disable iff (reset_in) // RL13
      boot_external_out |-> boot_mode_out)
      else $error("external boot without select");
   a_boot_secure: assert property (@(posedge clk_in) disable iff (reset_in) // RL13
      state_ff == rxirq_pkg::RXIRQ_ST_HELD && device_reset_n_in
      |=> boot_external_out == ($past(boot_source_select_in) && !$past(flash_secure_in)))
      else $error("external boot ignores security");
   a_debug_keep: assert property (@(posedge clk_in) disable iff (reset_in) // RL5
      test_reset_n_in && !device_reset_n_in |=> !debug_reset_out)
      else $error("debug reset by device pin");
   a_debug_follow: assert property (@(posedge clk_in) disable iff (reset_in) // RL4
      !reset_in |=> debug_reset_out == !$past(test_reset_n_in))
      else $error("debug reset does not follow test reset");
   a_por_first: assert property (@(posedge clk_in) $fell(reset_in) |-> core_reset_out [*2]) // RL6
      else $error("power-on reset not held");
   // eight is the default power-on stretch; keep in step with POR_CYCLES
   a_por_stretch: assert property (@(posedge clk_in) disable iff (reset_in) // RL6
      $fell(reset_in) |-> state_ff == rxirq_pkg::RXIRQ_ST_POR [*8]
      ##1 state_ff == rxirq_pkg::RXIRQ_ST_HELD)
      else $error("power-on stretch wrong length");
   a_lp_async: assert property (@(posedge clk_in) disable iff (reset_in) // RL9
      low_power_mode_in && !sense_edge_a_in && !sense_edge_b_in
      |-> request_a_out == !external_request_a_n_in && request_b_out == !external_request_b_n_in)
      else $error("low power request not passed straight");
   a_pullups: assert property (@(posedge clk_in) // RL7 RL12
      reset_pullup_en_out != pullup_disable_reg_in[`RXIRQ_PUD_RESET_BIT]
      && irq_pullup_en_out != pullup_disable_reg_in[`RXIRQ_PUD_IRQ_BIT])
      else $error("pull-up enable wrong");
   a_pullup_boot: assert property (@(posedge clk_in)
      boot_pullup_en_out != pullup_disable_reg_in[`RXIRQ_PUD_XBOOT_BIT])
      else $error("boot pull-up enable wrong");
endmodule : rxirq_top

// ### sim/rxirq_board.sv
// board side model: reset source, debugger and interrupting device
`timescale 1ns/100ps
module rxirq_board (
   // clock
   input wire logic clk_in,
   // pins toward the device
   output logic dev_rst_n_out,
   output logic tst_rst_n_out,
   output logic boot_sel_out,
   output logic req_a_n_out,
   output logic req_b_n_out
);
   // board powers up with both reset pins held low
   initial begin
      dev_rst_n_out = 1'h0;
      tst_rst_n_out = 1'h0;
      boot_sel_out = 1'h0;
      req_a_n_out = 1'h1;
      req_b_n_out = 1'h1;
   end
   // keep_dbg leaves test reset high so debug state survives
   task automatic hold_reset(input logic keep_dbg, input int cycles);
      @(negedge clk_in);
      dev_rst_n_out = 1'h0;
      tst_rst_n_out = keep_dbg;
      repeat (cycles) @(negedge clk_in);
   endtask : hold_reset
   // boot level is only held briefly, then flips so a late sample shows
   task automatic release_reset(input logic boot);
      @(negedge clk_in);
      boot_sel_out = boot;
      dev_rst_n_out = 1'h1;
      tst_rst_n_out = 1'h1;
      repeat (2) @(negedge clk_in);
      boot_sel_out = ~boot;
   endtask : release_reset
   // released request pins are driven back high by the board model
   task automatic set_req(input logic b, input logic low);
      if (b) begin
         req_b_n_out = ~low;
      end else begin
         req_a_n_out = ~low;
      end
   endtask : set_req
endmodule : rxirq_board

// ### sim/rxirq_top_tb.sv
// self-checking bench for the reset and request pin block
`timescale 1ns/100ps
`include "rxirq_consts.svh"
module rxirq_top_tb;
   logic clk_in = 1'h0;
   logic reset_in = 1'h1;
   logic secure = 1'h0;
   logic low_pwr = 1'h0;
   logic [`RXIRQ_PUD_W-1:0] pud = 3'h0;
   logic sense_a = 1'h0;
   logic sense_b = 1'h0;
   logic ack_a = 1'h0;
   logic ack_b = 1'h0;
   logic dev_rst_n, tst_rst_n, boot_sel, req_a_n, req_b_n;
   logic core_rst, dbg_rst, rst_state, boot_mode, boot_ext, rq_a, rq_b, pu_rst, pu_irq, pu_boot;
   int error_cnt = 0;
   int checks_done = 0;
   int cycle_cnt = 0;
   int n;
   // release is seen count plus the edge into COUNT, two of them spent in release_reset
   localparam int REL_SEEN = `RXIRQ_RELEASE_CYCLES + 1 - 2;

   always #5 clk_in = ~clk_in;

   rxirq_board board (.clk_in(clk_in), .dev_rst_n_out(dev_rst_n), .tst_rst_n_out(tst_rst_n),
      .boot_sel_out(boot_sel), .req_a_n_out(req_a_n), .req_b_n_out(req_b_n));

   rxirq_top dut (.clk_in(clk_in), .reset_in(reset_in), .device_reset_n_in(dev_rst_n),
      .test_reset_n_in(tst_rst_n), .boot_source_select_in(boot_sel), .external_request_a_n_in(req_a_n),
      .external_request_b_n_in(req_b_n), .flash_secure_in(secure), .low_power_mode_in(low_pwr),
      .pullup_disable_reg_in(pud), .sense_edge_a_in(sense_a), .sense_edge_b_in(sense_b),
      .ack_a_in(ack_a), .ack_b_in(ack_b), .core_reset_out(core_rst), .debug_reset_out(dbg_rst),
      .reset_state_out(rst_state), .boot_mode_out(boot_mode), .boot_external_out(boot_ext),
      .request_a_out(rq_a), .request_b_out(rq_b), .reset_pullup_en_out(pu_rst),
      .irq_pullup_en_out(pu_irq), .boot_pullup_en_out(pu_boot));

   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic check_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic check_num(input string what, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : check_num

   // bounded wait, in falling edges, for the internal reset to drop
   task automatic count_release(output int cnt);
      cnt = 0;
      while (core_rst !== 1'h0 && cnt < 60) begin
         @(negedge clk_in);
         cnt++;
      end
   endtask : count_release

   task automatic t_power_up();
      repeat (10) @(negedge clk_in);
      check_bit("core reset at power-up", 1'h1, core_rst);
      check_bit("debug reset full", 1'h1, dbg_rst);
      reset_in = 1'h0;
      repeat (12) @(negedge clk_in);
      check_bit("core reset pin low", 1'h1, core_rst);
      check_bit("reset state", 1'h1, rst_state);
      board.release_reset(1'h1);
      count_release(n);
      check_num("release cycles", REL_SEEN, n);
      check_bit("reset state", 1'h0, rst_state);
      check_bit("debug reset", 1'h0, dbg_rst);
      check_bit("boot mode", 1'h1, boot_mode);
      check_bit("boot external", 1'h1, boot_ext);
   endtask : t_power_up

   task automatic t_debug_keep();
      secure = 1'h1;
      board.hold_reset(1'h1, 5);
      check_bit("debug reset kept", 1'h0, dbg_rst);
      check_bit("core reset", 1'h1, core_rst);
      check_bit("reset state", 1'h1, rst_state);
      board.release_reset(1'h1);
      count_release(n);
      check_num("release cycles", REL_SEEN, n);
      check_bit("boot mode", 1'h1, boot_mode);
      check_bit("boot external secured", 1'h0, boot_ext);
      secure = 1'h0;
   endtask : t_debug_keep

   // power-on reset with the pin already high; requests refused meanwhile
   task automatic t_por_again();
      @(negedge clk_in);
      reset_in = 1'h1;
      board.set_req(1'h0, 1'h1);
      @(negedge clk_in);
      check_bit("core reset por", 1'h1, core_rst);
      reset_in = 1'h0;
      repeat (20) @(negedge clk_in);
      check_bit("core reset por stretch", 1'h1, core_rst);
      check_bit("request masked", 1'h0, rq_a);
      count_release(n);
      // twenty edges already waited above
      check_num("por release cycles", `RXIRQ_POR_CYCLES + `RXIRQ_RELEASE_CYCLES + 1 - 20, n);
      board.set_req(1'h0, 1'h0);
      repeat (4) @(negedge clk_in);
   endtask : t_por_again

   task automatic t_level(input logic b);
      @(negedge clk_in);
      board.set_req(b, 1'h1);
      repeat (2) @(negedge clk_in);
      check_bit("request before sync", 1'h0, b ? rq_b : rq_a);
      @(negedge clk_in);
      check_bit("request level", 1'h1, b ? rq_b : rq_a);
      check_bit("other request", 1'h0, b ? rq_a : rq_b);
      board.set_req(b, 1'h0);
      repeat (4) @(negedge clk_in);
      check_bit("request level off", 1'h0, b ? rq_b : rq_a);
   endtask : t_level

   // one-cycle pulse must stay pending until acknowledged
   task automatic t_edge(input logic b);
      @(negedge clk_in);
      board.set_req(b, 1'h1);
      @(negedge clk_in);
      board.set_req(b, 1'h0);
      repeat (4) @(negedge clk_in);
      check_bit("edge request", 1'h1, b ? rq_b : rq_a);
      repeat (6) @(negedge clk_in);
      check_bit("edge pending held", 1'h1, b ? rq_b : rq_a);
      ack_a = ~b;
      ack_b = b;
      @(negedge clk_in);
      ack_a = 1'h0;
      ack_b = 1'h0;
      repeat (2) @(negedge clk_in);
      check_bit("edge cleared", 1'h0, b ? rq_b : rq_a);
   endtask : t_edge

   task automatic t_async(input logic b);
      @(negedge clk_in);
      board.set_req(b, 1'h1);
      #1;
      check_bit("async request", 1'h1, b ? rq_b : rq_a);
      @(negedge clk_in);
      board.set_req(b, 1'h0);
      #1;
      check_bit("async request off", 1'h0, b ? rq_b : rq_a);
   endtask : t_async

   task automatic t_pullups();
      for (int v = 0; v < 8; v++) begin
         @(negedge clk_in);
         pud = `RXIRQ_PUD_W'(v);
         #1;
         check_bit("reset pull-up", ~pud[`RXIRQ_PUD_RESET_BIT], pu_rst);
         check_bit("request pull-up", ~pud[`RXIRQ_PUD_IRQ_BIT], pu_irq);
         check_bit("boot pull-up", ~pud[`RXIRQ_PUD_XBOOT_BIT], pu_boot);
      end
   endtask : t_pullups

   always @(posedge clk_in) begin
      cycle_cnt++;
      if (cycle_cnt == 3000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      t_power_up();
      t_debug_keep();
      t_por_again();
      t_level(1'h0);
      t_level(1'h1);
      sense_a = 1'h1;
      sense_b = 1'h1;
      t_edge(1'h0);
      t_edge(1'h1);
      sense_a = 1'h0;
      sense_b = 1'h0;
      low_pwr = 1'h1;
      t_async(1'h0);
      t_async(1'h1);
      t_pullups();
      final_report();
   end
endmodule : rxirq_top_tb
